// ### hdl/drs_seq.sv
// device-side sequencer: mode-register reset, zq calibration, power-down entry and exit
// assumes cmd and cke are synchronous to clk_sys_i, the memory clock
`include "drs_consts.svh"

// How it works
// - reset from idle restores mode register defaults
// - array data undefined after reset
// - four zq commands decoded from mrw
// - zq reset restores default driver impedance
// - zq current path off after calibration
// - zq tied high ignores calibration commands
// - cke falling with cs high enters power-down
// - power-down classed idle or active
// - buffers off in power-down except clock/cke
// - no refresh while powered down
// - cke high exits power-down
// - mrw decoded from cs low, ca3:0 low
module drs_seq
  import drs_pkg::*;
#(
  parameter int RESET_HOLD_CYC = `DRS_CYC(`DRS_RESET_HOLD_NS),
  parameter int INIT_CAL_CYC   = `DRS_CYC(`DRS_INIT_CAL_NS),
  parameter int LONG_CAL_CYC   = `DRS_CYC(`DRS_LONG_CAL_NS),
  parameter int SHORT_CAL_CYC  = `DRS_CYC(`DRS_SHORT_CAL_NS),
  parameter int CAL_RESET_CYC  = `DRS_CYC(`DRS_CAL_RESET_NS),
  parameter int CKE_MIN_CYC    = `DRS_CYC(`DRS_CKE_MIN_NS),
  parameter int PD_EXIT_CYC    = `DRS_CYC(`DRS_PD_EXIT_NS)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        cke_i,
  input  drs_pkg::drs_cmd_type cmd_i,
  input  wire logic        banks_open_i,
  input  wire logic        zq_tied_high_i,
  output drs_pkg::drs_stat_type stat_o,
  output logic [3:0]       driver_impedance_o,
  output logic [7:0]       mr_default_pulse_o,
  output logic             array_undefined_o,
  output logic             refresh_allow_o
);
  import drs_pkg::*;

  localparam int TW = 17;

  initial begin
    if (INIT_CAL_CYC >= (1 << TW) || RESET_HOLD_CYC >= (1 << TW)) $error("drs_seq period too long");
    if (CAL_RESET_CYC < 1 || CKE_MIN_CYC < 1 || PD_EXIT_CYC < 1) $error("drs_seq period below one cycle");
  end

  drs_state_type state_r, state_nxt;
  logic          cke_prev_r;
  logic [3:0]    imp_r, imp_nxt;
  logic [7:0]    mrdef_r;
  logic          undef_r, active_pd_r, zq_on_r, zq_on_nxt;
  logic          in_pd_r, resetting_r, calibrating_r, buffers_on_r, refresh_allow_r;

  wire is_mrw    = !cmd_i.cs_n && (cmd_i.ca_rise[3:0] == 4'h0);
  wire [7:0] mra = {cmd_i.ca_fall[1:0], cmd_i.ca_rise[9:4]};
  wire [7:0] mrd = cmd_i.ca_fall[9:2];
  wire do_reset  = (state_r == DRS_IDLE) && cke_i && is_mrw && (mra == `DRS_MR_RESET);
  wire zq_cmd    = (state_r == DRS_IDLE) && cke_i && is_mrw && (mra == `DRS_MR_ZQ);
  wire zq_init   = zq_cmd && (mrd == `DRS_ZQ_INIT);
  wire zq_long   = zq_cmd && (mrd == `DRS_ZQ_LONG);
  wire zq_short  = zq_cmd && (mrd == `DRS_ZQ_SHORT);
  wire zq_rst    = zq_cmd && (mrd == `DRS_ZQ_RESET);
  wire zq_go     = !zq_tied_high_i && (zq_init || zq_long || zq_short || zq_rst);
  // entry needs cke high before, low now, cs high
  wire pd_entry  = (state_r == DRS_IDLE) && cke_prev_r && !cke_i && cmd_i.cs_n;
  wire pd_exit   = (state_r == DRS_PD) && cke_i;

  wire [TW-1:0] load_cnt =
      do_reset ? TW'(RESET_HOLD_CYC) :
      zq_init  ? TW'(INIT_CAL_CYC)   :
      zq_long  ? TW'(LONG_CAL_CYC)   :
      zq_short ? TW'(SHORT_CAL_CYC)  :
      zq_rst   ? TW'(CAL_RESET_CYC)  :
      pd_exit  ? TW'(PD_EXIT_CYC)    : TW'(0);
  wire timer_load = do_reset || zq_go || pd_exit;
  wire timer_busy;

  drs_period_timer #(.WIDTH(TW)) u_timer (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .load_i    (timer_load),
    .count_i   (load_cnt),
    .busy_o    (timer_busy)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DRS_IDLE: begin
        if (do_reset) state_nxt = DRS_RESET;
        else if (zq_go) state_nxt = DRS_CAL;
        else if (pd_entry) state_nxt = DRS_PD;
      end
      DRS_RESET: if (!timer_busy) state_nxt = DRS_IDLE;
      DRS_CAL:   if (!timer_busy) state_nxt = DRS_IDLE;
      DRS_PD:    if (pd_exit) state_nxt = DRS_EXIT;
      DRS_EXIT:  if (!timer_busy) state_nxt = DRS_IDLE;
      default:   state_nxt = DRS_IDLE;
    endcase
  end

  // zq reset and device reset return the default impedance
  assign imp_nxt = (do_reset || (zq_rst && !zq_tied_high_i)) ? `DRS_IMP_DEFAULT :
                   (zq_go ? `DRS_IMP_CALIBRATED : imp_r);
  // current path only during a real calibration
  assign zq_on_nxt = (state_nxt == DRS_CAL);

  // status decoded from the next state, so every status output leaves a flop
  wire pd_nxt  = (state_nxt == DRS_PD);
  wire rst_nxt = (state_nxt == DRS_RESET);
  wire cal_nxt = (state_nxt == DRS_CAL);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r     <= DRS_IDLE;
      cke_prev_r  <= 1'b0;
      imp_r       <= `DRS_IMP_DEFAULT;
      mrdef_r     <= 8'h00;
      undef_r     <= 1'b1;
      active_pd_r <= 1'b0;
      zq_on_r     <= 1'b0;
      in_pd_r         <= 1'b0;
      resetting_r     <= 1'b0;
      calibrating_r   <= 1'b0;
      buffers_on_r    <= 1'b1;
      refresh_allow_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      cke_prev_r  <= cke_i;
      imp_r       <= imp_nxt;
      // one-cycle pulse restoring mode register defaults
      mrdef_r     <= do_reset ? 8'hff : 8'h00;
      undef_r     <= do_reset ? 1'b1 : undef_r;
      active_pd_r <= pd_entry ? banks_open_i : active_pd_r;
      zq_on_r     <= zq_on_nxt;
      in_pd_r         <= pd_nxt;
      resetting_r     <= rst_nxt;
      calibrating_r   <= cal_nxt;
      buffers_on_r    <= !pd_nxt;
      refresh_allow_r <= !pd_nxt;
    end
  end

  assign stat_o.in_pd         = in_pd_r;
  assign stat_o.active_pd     = active_pd_r;
  assign stat_o.resetting     = resetting_r;
  assign stat_o.calibrating   = calibrating_r;
  assign stat_o.zq_current_on = zq_on_r;
  assign stat_o.buffers_on    = buffers_on_r;
  assign driver_impedance_o   = imp_r;
  assign mr_default_pulse_o   = mrdef_r;
  assign array_undefined_o    = undef_r;
  assign refresh_allow_o      = refresh_allow_r;

  // entry one cycle after the sampling edge
  property p_pd_entry;
    @(posedge clk_sys_i) disable iff (!resetn_i) pd_entry |=> stat_o.in_pd;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_pd_exit;
    @(posedge clk_sys_i) disable iff (!resetn_i) (stat_o.in_pd && cke_i) |=> !stat_o.in_pd;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down not exited");

  // reset pulses defaults and enters resetting
  property p_reset;
    @(posedge clk_sys_i) disable iff (!resetn_i) do_reset |=> (mr_default_pulse_o == 8'hff) && stat_o.resetting;
  endproperty
  a_reset: assert property (p_reset) else $error("mode register reset not applied");

  property p_zq_tied;
    @(posedge clk_sys_i) disable iff (!resetn_i) (zq_cmd && zq_tied_high_i && stat_o.buffers_on) |=> !stat_o.calibrating;
  endproperty
  a_zq_tied: assert property (p_zq_tied) else $error("calibration with zq tied high");

  property p_zq_rst;
    @(posedge clk_sys_i) disable iff (!resetn_i) (zq_rst && !zq_tied_high_i) |=> driver_impedance_o == `DRS_IMP_DEFAULT;
  endproperty
  a_zq_rst: assert property (p_zq_rst) else $error("zq reset impedance wrong");

  property p_zq_off;
    @(posedge clk_sys_i) disable iff (!resetn_i) $fell(stat_o.calibrating) |-> !stat_o.zq_current_on;
  endproperty
  a_zq_off: assert property (p_zq_off) else $error("zq current left on");

  property p_buf;
    @(posedge clk_sys_i) disable iff (!resetn_i) stat_o.in_pd |-> !stat_o.buffers_on && !refresh_allow_o;
  endproperty
  a_buf: assert property (p_buf) else $error("buffers on in power-down");

  // class follows bank state at entry
  property p_class;
    @(posedge clk_sys_i) disable iff (!resetn_i) pd_entry |=> stat_o.active_pd == $past(banks_open_i);
  endproperty
  a_class: assert property (p_class) else $error("power-down class wrong");

  property p_short;
    @(posedge clk_sys_i) disable iff (!resetn_i) (zq_short && !zq_tied_high_i) |=> stat_o.calibrating [*2];
  endproperty
  a_short: assert property (p_short) else $error("short calibration too brief");
endmodule

// ### hdl/drs_consts.svh
// timing counts, mode register numbers and reset values for the reset/zq/power-down sequencer
// assumes a 50 MHz system clock
`ifndef DRS_CONSTS_SVH
`define DRS_CONSTS_SVH
`define DRS_CLK_NS            20
// periods in ns
`define DRS_RESET_HOLD_NS     10000
`define DRS_INIT_CAL_NS       1000000
`define DRS_LONG_CAL_NS       360
`define DRS_SHORT_CAL_NS      90
`define DRS_CAL_RESET_NS      50
`define DRS_CKE_MIN_NS        15
`define DRS_PD_EXIT_NS        15
// least times round up to cycles
`define DRS_CYC(ns)           (((ns) + `DRS_CLK_NS - 1) / `DRS_CLK_NS)
// mode register numbers and zq command codes
`define DRS_MR_RESET          8'h3f
`define DRS_MR_ZQ             8'h0a
`define DRS_ZQ_INIT           8'hff
`define DRS_ZQ_LONG           8'hab
`define DRS_ZQ_SHORT          8'h56
`define DRS_ZQ_RESET          8'hc3
// reset values and the calibrated impedance
`define DRS_MR_DEFAULT        8'h00
`define DRS_IMP_DEFAULT       4'h8
`define DRS_IMP_CALIBRATED    4'h4
`endif

// ### hdl/drs_pkg.sv
// types for the reset/zq/power-down sequencer
// assumes drs_consts.svh on the include path
package drs_pkg;
  typedef struct packed {
    logic       cs_n;
    logic [9:0] ca_rise;
    logic [9:0] ca_fall;
  } drs_cmd_type;

  typedef struct packed {
    logic       in_pd;
    logic       active_pd;
    logic       resetting;
    logic       calibrating;
    logic       zq_current_on;
    logic       buffers_on;
  } drs_stat_type;

  typedef enum logic [4:0] {
    DRS_IDLE  = 5'b00001,
    DRS_RESET = 5'b00010,
    DRS_CAL   = 5'b00100,
    DRS_PD    = 5'b01000,
    DRS_EXIT  = 5'b10000
  } drs_state_type;
endpackage

// ### hdl/drs_period_timer.sv
// down counter timing one busy period
// assumes load pulses only when the caller is idle
module drs_period_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  busy_o
);
  logic [WIDTH-1:0] cnt_r;
  wire  [WIDTH-1:0] cnt_nxt = load_i ? count_i : (cnt_r != '0 ? cnt_r - 1'b1 : cnt_r);

  initial begin
    if (WIDTH < 2) $error("drs_period_timer width too small");
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) cnt_r <= '0;
    else cnt_r <= cnt_nxt;
  end

  assign busy_o = (cnt_r > 1);
endmodule

// ### tb/drs_ctrl_model.sv
// controller model: drives cke and the command bus toward the sequencer
// assumes the bench calls its tasks; every change lands on a falling edge
module drs_ctrl_model (
  input  wire logic         clk_sys_i,
  output logic              cke_o,
  output drs_pkg::drs_cmd_type cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import drs_pkg::*;

  initial begin
    cke_o = 1'b1;
    cmd_o = '{cs_n: 1'b1, ca_rise: 10'h155, ca_fall: 10'h2aa};
  end

  // deselect only
  // no data bus and a single device: no quiet window or shared resistor to clash with
  // ca lines flip each cycle so a stale value is never mistaken for a command
  task automatic nops(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      cmd_o.cs_n    = 1'b1;
      cmd_o.ca_rise = ~cmd_o.ca_rise;
      cmd_o.ca_fall = ~cmd_o.ca_fall;
    end
  endtask

  task automatic mrw(input logic [7:0] ma, input logic [7:0] data);
    @(negedge clk_sys_i);
    cmd_o = '{cs_n: 1'b0, ca_rise: {ma[5:0], 4'h0}, ca_fall: {data, ma[7:6]}};
    nops(1);
  endtask

  task automatic set_cke(input logic lvl);
    @(negedge clk_sys_i);
    cke_o      = lvl;
    cmd_o.cs_n = 1'b1;
  endtask
endmodule

// ### tb/test_drs_seq.sv
// self-checking bench for the reset/zq/power-down sequencer
// assumes drs_ctrl_model drives cke and commands on falling edges
`include "drs_consts.svh"
module test_drs_seq;
  timeunit 1ns;
  timeprecision 1ns;
  import drs_pkg::*;
  localparam int HOLD   = 30;
  localparam int CAL[4] = '{20, `DRS_CYC(`DRS_LONG_CAL_NS), `DRS_CYC(`DRS_CAL_RESET_NS), `DRS_CYC(`DRS_SHORT_CAL_NS)};
  localparam logic [7:0] CODE[4] = '{`DRS_ZQ_INIT, `DRS_ZQ_LONG, `DRS_ZQ_RESET, `DRS_ZQ_SHORT};
  localparam logic [3:0] IMP[4]  = '{4'h4, 4'h4, 4'h8, 4'h4};
  logic         clk_sys_i;
  logic         resetn_i;
  logic         cke_i;
  logic         banks_open_i;
  logic         zq_tied_high_i;
  drs_cmd_type  cmd_i;
  drs_stat_type stat_o;
  logic [3:0]   driver_impedance_o;
  logic [7:0]   mr_default_pulse_o;
  logic         array_undefined_o;
  logic         refresh_allow_o;
  int           mismatches;
  int           comparisons;
  int           cycles;

  // only the two very long periods are shortened; the rest run at their defaults
  drs_seq #(.RESET_HOLD_CYC(HOLD), .INIT_CAL_CYC(CAL[0])) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cke_i(cke_i), .cmd_i(cmd_i),
    .banks_open_i(banks_open_i), .zq_tied_high_i(zq_tied_high_i), .stat_o(stat_o),
    .driver_impedance_o(driver_impedance_o), .mr_default_pulse_o(mr_default_pulse_o),
    .array_undefined_o(array_undefined_o), .refresh_allow_o(refresh_allow_o));

  drs_ctrl_model i_ctrl (.clk_sys_i(clk_sys_i), .cke_o(cke_i), .cmd_o(cmd_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // busy flag must last n or n-1 cycles
  task automatic span(input string what, input int n, input bit rst);
    int len;
    len = 0;
    while ((rst ? stat_o.resetting : stat_o.calibrating) === 1'b1 && len < 2000) begin
      len++;
      i_ctrl.nops(1);
    end
    chk(what, 8'h01, 8'((len >= n - 1) && (len <= n)));
  endtask

  task automatic t_defaults();
    chk("buffers_on", 8'h01, 8'(stat_o.buffers_on));
    chk("impedance", 8'h08, 8'(driver_impedance_o));
    chk("refresh_allow", 8'h01, 8'(refresh_allow_o));
    $display("test defaults done");
  endtask

  task automatic t_cal();
    for (int k = 0; k < 4; k++) begin
      i_ctrl.mrw(8'h0a, CODE[k]);
      chk("calibrating", 8'h01, 8'(stat_o.calibrating));
      chk("zq_current_on during cal", 8'h01, 8'(stat_o.zq_current_on));
      span("cal length", CAL[k], 1'b0);
      chk("impedance", 8'(IMP[k]), 8'(driver_impedance_o));
      chk("zq_current_on", 8'h00, 8'(stat_o.zq_current_on));
    end
    $display("test calibration done");
  endtask

  task automatic t_tied();
    zq_tied_high_i = 1'b1;
    i_ctrl.mrw(8'h0a, 8'hc3);
    chk("tied calibrating", 8'h00, 8'(stat_o.calibrating));
    chk("tied zq_current_on", 8'h00, 8'(stat_o.zq_current_on));
    i_ctrl.nops(4);
    chk("tied impedance", 8'h04, 8'(driver_impedance_o));
    zq_tied_high_i = 1'b0;
    i_ctrl.mrw(8'h0a, 8'h11);
    chk("unknown code calibrating", 8'h00, 8'(stat_o.calibrating));
    chk("unknown code impedance", 8'h04, 8'(driver_impedance_o));
    $display("test tied done");
  endtask

  task automatic t_pd(input logic banks);
    banks_open_i = banks;
    i_ctrl.set_cke(1'b0);
    i_ctrl.nops(1);
    chk("in_pd", 8'h01, 8'(stat_o.in_pd));
    chk("active_pd", 8'(banks), 8'(stat_o.active_pd));
    chk("pd buffers_on", 8'h00, 8'(stat_o.buffers_on));
    chk("pd refresh_allow", 8'h00, 8'(refresh_allow_o));
    i_ctrl.mrw(8'h0a, 8'h56);
    chk("pd calibrating", 8'h00, 8'(stat_o.calibrating));
    i_ctrl.set_cke(1'b1);
    i_ctrl.nops(1);
    chk("exit in_pd", 8'h00, 8'(stat_o.in_pd));
    i_ctrl.nops(2);
    chk("exit buffers_on", 8'h01, 8'(stat_o.buffers_on));
    chk("exit refresh_allow", 8'h01, 8'(refresh_allow_o));
    banks_open_i = 1'b0;
    $display("test power down done");
  endtask

  task automatic t_reset();
    i_ctrl.mrw(8'h3f, 8'h00);
    chk("resetting", 8'h01, 8'(stat_o.resetting));
    chk("mr default pulse", 8'hff, mr_default_pulse_o);
    chk("array undefined", 8'h01, 8'(array_undefined_o));
    chk("reset impedance", 8'h08, 8'(driver_impedance_o));
    i_ctrl.nops(1);
    chk("pulse width", 8'h00, mr_default_pulse_o);
    span("reset hold", HOLD - 1, 1'b1);
    $display("test reset done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // the whole run needs about 120 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    resetn_i       = 1'b0;
    banks_open_i   = 1'b0;
    zq_tied_high_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_defaults();
    t_cal();
    t_tied();
    t_pd(1'b0);
    t_pd(1'b1);
    t_reset();
    summarize();
  end
endmodule
